// ---- rtl/seq_pkg.sv ----
package seq_pkg;
    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int  CLK_HZ          = 40_000_000;
    localparam int  MS_NS           = 1_000_000;
    localparam int  CLK_NS          = 25;
    localparam int  MS_CYCLES       = MS_NS / CLK_NS;
    // parallel-VOLTAGE_ID_CODE slew: 0.625 mV/us, i.e. one 10 mV step per 16 us
    localparam int  SLEW_UV_PER_US  = 625;
    localparam int  VID_STEP_UV     = 10_000;
    localparam int  SLEW_STEP_US    = VID_STEP_UV / SLEW_UV_PER_US;
    localparam int  SLEW_STEP_CYCLES = (VID_STEP_UV * 1000 / SLEW_UV_PER_US) * 1000 / CLK_NS / 1000;
    localparam int  VID_STEP_MV     = 10;
    // base one step below code 1; code zero itself maps to 0 mV
    localparam logic [15:0] VID_BASE_MV = 16'h01EA;
    // --------------------------------------------------------------
    // register map (word index == byte address / 4)
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_VIN_ON  = 8'h04;
    localparam logic [7:0] ADDR_VIN_OFF = 8'h08;
    localparam logic [7:0] ADDR_TON_DLY = 8'h0C;
    localparam logic [7:0] ADDR_TON_RISE = 8'h10;
    localparam logic [7:0] ADDR_FREQ    = 8'h14;
    localparam logic [7:0] ADDR_VID     = 8'h18;
    localparam logic [7:0] ADDR_STATUS  = 8'h1C;
    // control fields
    localparam int  CTRL_SW_EN      = 0;
    localparam int  CTRL_USE_PIN    = 1;
    localparam int  CTRL_USE_SW     = 2;
    localparam int  CTRL_PARALLEL_VID_MODE       = 3;
    // reset values
    localparam logic [3:0]  CTRL_RST     = 4'h2;
    localparam logic [15:0] VIN_ON_RST   = 16'h1F40;
    localparam logic [15:0] VIN_OFF_RST  = 16'h1B58;
    localparam logic [6:0]  TON_DLY_RST  = 7'h00;
    localparam logic [6:0]  TON_RISE_RST = 7'h01;
    localparam logic [10:0] FREQ_RST     = 11'h258;
    localparam logic [10:0] FREQ_MIN_KHZ = 11'h096;
    localparam logic [10:0] FREQ_MAX_KHZ = 11'h5DC;
    localparam logic [7:0]  VID_RST      = 8'h00;
    // ramp of the low-side pulse: eighths of a period, 16 cycles per step
    localparam logic [3:0]  LS_EIGHTHS   = 4'h8;
    localparam logic [3:0]  LS_HOLD      = 4'hF;
    // --------------------------------------------------------------
    // sequencer states
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DELAY,
        ST_RAMP,
        ST_ON
    } seq_state_t;
    // VOLTAGE_ID_CODE code to reference in millivolts, 10 mV per code
    function automatic logic [15:0] vid_to_mv(input logic [7:0] code);
        if (code == 8'h00) begin
            vid_to_mv = 16'h0000;
        end else begin
            vid_to_mv = 16'(VID_BASE_MV + 16'(code) * 16'(VID_STEP_MV));
        end
    endfunction
endpackage

// ---- rtl/ls_ramp_if.sv ----
`timescale 1ns/1ps
// --------------------------------------------------------------
// low-side pulse ramp handshake
// --------------------------------------------------------------
interface ls_ramp_if;
    logic       start;
    logic       cycle_tick;
    logic [3:0] width_eighths;
    logic       done;
    modport ctrl (output start, output cycle_tick, input width_eighths, input done);
    modport ramp (input start, input cycle_tick, output width_eighths, output done);
endinterface // ls_ramp_if

// ---- rtl/ls_ramp.sv ----
`timescale 1ns/1ps
module ls_ramp (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // control
    ls_ramp_if.ramp   rif
);
    logic [3:0] width_q;
    logic [3:0] hold_q;
    logic       run_q;

    // --------------------------------------------------------------
    // eighth-period steps, each held for 16 switching cycles
    // --------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            width_q <= 4'h0;
            hold_q  <= 4'h0;
            run_q   <= 1'b0;
        end else if (!rif.start) begin
            width_q <= 4'h0;
            hold_q  <= 4'h0;
            run_q   <= 1'b0;
        end else if (!run_q) begin
            width_q <= 4'h1;
            hold_q  <= 4'h0;
            run_q   <= 1'b1;
        end else if (rif.cycle_tick && width_q != seq_pkg::LS_EIGHTHS) begin
            hold_q <= 4'(hold_q + 4'h1);
            if (hold_q == seq_pkg::LS_HOLD) begin
                width_q <= 4'(width_q + 4'h1);
            end
        end
    end

    assign rif.width_eighths = width_q;
    assign rif.done          = (width_q == seq_pkg::LS_EIGHTHS);

    a_step_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (run_q && rif.start && width_q != 4'h0 && $changed(width_q))
            |-> $past(hold_q) == seq_pkg::LS_HOLD || $past(run_q) == 1'b0)
        else $error("low-side step changed before 16 cycles");
endmodule // ls_ramp

// ---- rtl/reg_startup_seq.sv ----
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - convert only with supply and enable comparators
// - lockout thresholds default 8 V on, 7 V off, programmable
// - lockout uses comparators, ADC only reports
// - input reading never affects feedforward
// - low-side off until first high-side pulse
// - low-side pulse grows eighths, 16 cycles each
// - ramp starts only after full enable
// - optional software enable, with or instead
// - bus mode turn-on delay 0-127 ms
// - bus mode ramp time 1-127 ms
// - delay ignored in parallel-VOLTAGE_ID_CODE mode
// - parallel-VOLTAGE_ID_CODE ramp slews 0.625 mV/us
// - current and voltage protection stay armed
// - switching frequency programmable 150 kHz-1.5 MHz
// - each code step adds 10 mV
module reg_startup_seq #(
    parameter int MS_CYC   = seq_pkg::MS_CYCLES,
    parameter int SLEW_CYC = seq_pkg::SLEW_STEP_CYCLES
) (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    // analog comparators and status
    input  wire logic        bus_input_supply_ok_in,
    input  wire logic        enable_pin_ok_in,
    input  wire logic        config_loaded_in,
    input  wire logic [7:0]  voltage_id_code_in,
    input  wire logic        switch_cycle_in,
    input  wire logic        high_side_pulse_in,
    input  wire logic [15:0] vin_adc_in,
    // register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    // power stage
    output logic             convert_en_out,
    output logic             high_side_switch_en_out,
    output logic             low_side_switch_en_out,
    output logic      [3:0]  low_side_width_out,
    output logic      [15:0] vref_mv_out,
    output logic      [15:0] vin_on_out,
    output logic      [15:0] vin_off_out,
    output logic      [10:0] freq_khz_out,
    output logic             protect_armed_out,
    output logic      [15:0] vin_report_out
);
    // --------------------------------------------------------------
    // reset release and input synchronisers
    // --------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_b;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_q[1];

    localparam int NSYNC = 5;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [NSYNC-1:0] raw;
    assign raw = {high_side_pulse_in, switch_cycle_in, config_loaded_in,
                  enable_pin_ok_in, bus_input_supply_ok_in};
    always_ff @(posedge mclk_in or negedge rst_b) begin
        if (!rst_b) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < NSYNC; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    lvl_q[i] <= s3_q[i];
                end
            end
        end
    end
    logic supply_ok, pin_ok, cfg_ok, sw_cyc, hs_pulse, sw_cyc_d_q, hs_d_q;
    assign supply_ok = lvl_q[0];
    assign pin_ok    = lvl_q[1];
    assign cfg_ok    = lvl_q[2];
    always_ff @(posedge mclk_in or negedge rst_b) begin
        if (!rst_b) begin
            sw_cyc_d_q <= 1'b0;
            hs_d_q     <= 1'b0;
        end else begin
            sw_cyc_d_q <= lvl_q[3];
            hs_d_q     <= lvl_q[4];
        end
    end
    assign sw_cyc   = lvl_q[3] && !sw_cyc_d_q;
    assign hs_pulse = lvl_q[4] && !hs_d_q;

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    logic [3:0]  ctrl_q;
    logic [15:0] vin_on_q, vin_off_q;
    logic [6:0]  ton_dly_q, ton_rise_q;
    logic [10:0] freq_q;
    logic [7:0]  vid_reg_q;
    seq_pkg::seq_state_t state_q;

    always_ff @(posedge mclk_in or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q     <= seq_pkg::CTRL_RST;
            vin_on_q   <= seq_pkg::VIN_ON_RST;
            vin_off_q  <= seq_pkg::VIN_OFF_RST;
            ton_dly_q  <= seq_pkg::TON_DLY_RST;
            ton_rise_q <= seq_pkg::TON_RISE_RST;
            freq_q     <= seq_pkg::FREQ_RST;
            vid_reg_q  <= seq_pkg::VID_RST;
        end else if (wr_in) begin
            case (addr_in)
                seq_pkg::ADDR_CTRL:     ctrl_q    <= wdata_in[3:0];
                seq_pkg::ADDR_VIN_ON:   vin_on_q  <= wdata_in[15:0];
                seq_pkg::ADDR_VIN_OFF:  vin_off_q <= wdata_in[15:0];
                seq_pkg::ADDR_TON_DLY:  ton_dly_q <= wdata_in[6:0];
                seq_pkg::ADDR_TON_RISE: begin
                    if (wdata_in[6:0] != 7'h00) begin
                        ton_rise_q <= wdata_in[6:0];
                    end
                end
                seq_pkg::ADDR_FREQ: begin
                    if (wdata_in[10:0] >= seq_pkg::FREQ_MIN_KHZ &&
                        wdata_in[10:0] <= seq_pkg::FREQ_MAX_KHZ) begin
                        freq_q <= wdata_in[10:0];
                    end
                end
                seq_pkg::ADDR_VID:      vid_reg_q <= wdata_in[7:0];
                default: ;
            endcase
        end
    end

    // --------------------------------------------------------------
    // enable qualification
    // --------------------------------------------------------------
    logic enabled;
    logic parallel_vid_mode_mode;
    assign parallel_vid_mode_mode = ctrl_q[seq_pkg::CTRL_PARALLEL_VID_MODE];
    always_comb begin
        enabled = supply_ok && cfg_ok;
        if (ctrl_q[seq_pkg::CTRL_USE_PIN]) begin
            enabled = enabled && pin_ok;
        end
        if (ctrl_q[seq_pkg::CTRL_USE_SW]) begin
            enabled = enabled && ctrl_q[seq_pkg::CTRL_SW_EN];
        end
        if (!ctrl_q[seq_pkg::CTRL_USE_PIN] && !ctrl_q[seq_pkg::CTRL_USE_SW]) begin
            enabled = 1'b0;
        end
    end

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    logic [7:0]  target_code;
    logic [15:0] target_mv;
    logic [16:0] ms_cnt_q;
    logic [6:0]  ms_q;
    logic [15:0] slew_cnt_q;
    logic [15:0] vref_q;
    logic        ms_tick;
    logic [31:0] ramp_num;

    assign target_code = parallel_vid_mode_mode ? voltage_id_code_in : vid_reg_q;
    assign target_mv   = seq_pkg::vid_to_mv(target_code);
    assign ms_tick     = (ms_cnt_q == 17'(MS_CYC - 1));
    assign ramp_num    = 32'(target_mv) * 32'(7'(ms_q + 7'h1));

    always_ff @(posedge mclk_in or negedge rst_b) begin
        if (!rst_b) begin
            ms_cnt_q <= '0;
        end else if (state_q == seq_pkg::ST_IDLE || ms_tick) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= 17'(ms_cnt_q + 17'h1);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= seq_pkg::ST_IDLE;
            ms_q       <= '0;
            slew_cnt_q <= '0;
            vref_q     <= '0;
        end else if (!enabled) begin
            state_q <= seq_pkg::ST_IDLE;
            ms_q    <= '0;
            vref_q  <= '0;
        end else begin
            case (state_q)
                seq_pkg::ST_IDLE: begin
                    ms_q <= '0;
                    if (parallel_vid_mode_mode || ton_dly_q == 7'h00) begin
                        state_q <= seq_pkg::ST_RAMP;
                    end else begin
                        state_q <= seq_pkg::ST_DELAY;
                    end
                end
                seq_pkg::ST_DELAY: begin
                    vref_q <= '0;
                    if (ms_tick) begin
                        ms_q <= 7'(ms_q + 7'h1);
                        if (7'(ms_q + 7'h1) == ton_dly_q) begin
                            state_q <= seq_pkg::ST_RAMP;
                            ms_q    <= '0;
                        end
                    end
                end
                seq_pkg::ST_RAMP: begin
                    if (parallel_vid_mode_mode) begin
                        slew_cnt_q <= 16'(slew_cnt_q + 16'h1);
                        if (slew_cnt_q == 16'(SLEW_CYC - 1)) begin
                            slew_cnt_q <= '0;
                            vref_q <= (vref_q + 16'(seq_pkg::VID_STEP_MV) >= target_mv) ?
                                      target_mv : 16'(vref_q + 16'(seq_pkg::VID_STEP_MV));
                        end
                        if (vref_q >= target_mv) begin
                            state_q <= seq_pkg::ST_ON;
                        end
                    end else if (ms_tick) begin
                        ms_q    <= 7'(ms_q + 7'h1);
                        vref_q  <= 16'(ramp_num / 32'(ton_rise_q));
                        if (7'(ms_q + 7'h1) == ton_rise_q) begin
                            state_q <= seq_pkg::ST_ON;
                        end
                    end
                end
                seq_pkg::ST_ON: vref_q <= target_mv;
                default: state_q <= seq_pkg::ST_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // pre-bias low-side gating
    // --------------------------------------------------------------
    logic    first_hs_q;
    ls_ramp_if lr();
    always_ff @(posedge mclk_in or negedge rst_b) begin
        if (!rst_b) begin
            first_hs_q <= 1'b0;
        end else if (state_q == seq_pkg::ST_IDLE || state_q == seq_pkg::ST_DELAY) begin
            first_hs_q <= 1'b0;
        end else if (hs_pulse) begin
            first_hs_q <= 1'b1;
        end
    end
    assign lr.start      = first_hs_q;
    assign lr.cycle_tick = sw_cyc;
    ls_ramp u_ls_ramp (
        .clk_in   (mclk_in),
        .rst_b_in (rst_b),
        .rif      (lr)
    );

    // --------------------------------------------------------------
    // outputs and register read
    // --------------------------------------------------------------
    logic running;
    assign running = (state_q == seq_pkg::ST_RAMP || state_q == seq_pkg::ST_ON);
    always_ff @(posedge mclk_in or negedge rst_b) begin
        if (!rst_b) begin
            convert_en_out          <= 1'b0;
            high_side_switch_en_out <= 1'b0;
            low_side_switch_en_out  <= 1'b0;
            low_side_width_out      <= '0;
            vref_mv_out             <= '0;
            vin_on_out              <= seq_pkg::VIN_ON_RST;
            vin_off_out             <= seq_pkg::VIN_OFF_RST;
            freq_khz_out            <= seq_pkg::FREQ_RST;
            protect_armed_out       <= 1'b0;
            vin_report_out          <= '0;
            rdata_out               <= '0;
        end else begin
            convert_en_out          <= enabled;
            high_side_switch_en_out <= running && enabled;
            low_side_switch_en_out  <= running && enabled && first_hs_q;
            low_side_width_out      <= first_hs_q ? lr.width_eighths : 4'h0;
            vref_mv_out             <= vref_q;
            vin_on_out              <= vin_on_q;
            vin_off_out             <= vin_off_q;
            freq_khz_out            <= freq_q;
            protect_armed_out       <= 1'b1;
            vin_report_out          <= vin_adc_in;
            rdata_out               <= '0;
            if (rd_in) begin
                case (addr_in)
                    seq_pkg::ADDR_CTRL:     rdata_out <= 32'(ctrl_q);
                    seq_pkg::ADDR_VIN_ON:   rdata_out <= 32'(vin_on_q);
                    seq_pkg::ADDR_VIN_OFF:  rdata_out <= 32'(vin_off_q);
                    seq_pkg::ADDR_TON_DLY:  rdata_out <= 32'(ton_dly_q);
                    seq_pkg::ADDR_TON_RISE: rdata_out <= 32'(ton_rise_q);
                    seq_pkg::ADDR_FREQ:     rdata_out <= 32'(freq_q);
                    seq_pkg::ADDR_VID:      rdata_out <= 32'(vid_reg_q);
                    seq_pkg::ADDR_STATUS:   rdata_out <= {24'h0, lr.done, first_hs_q,
                                                          enabled, 2'b00, 3'(state_q)};
                    default:                rdata_out <= '0;
                endcase
            end
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_enable_gate: assert property (@(posedge mclk_in) disable iff (!rst_b)
        convert_en_out |-> $past(supply_ok) && $past(cfg_ok))
        else $error("conversion enabled without supply or config");
    a_delay_off: assert property (@(posedge mclk_in) disable iff (!rst_b)
        state_q == seq_pkg::ST_DELAY ##1 state_q == seq_pkg::ST_DELAY
            |-> !high_side_switch_en_out && vref_q == 16'h0000)
        else $error("drivers or reference active during delay");
    a_abort_idle: assert property (@(posedge mclk_in) disable iff (!rst_b)
        !enabled |=> state_q == seq_pkg::ST_IDLE ##1 !high_side_switch_en_out)
        else $error("enable loss did not abort");
    a_ls_first_hs: assert property (@(posedge mclk_in) disable iff (!rst_b)
        low_side_switch_en_out |-> $past(first_hs_q))
        else $error("low side before first high side pulse");
    a_parallel_vid_mode_nodly: assert property (@(posedge mclk_in) disable iff (!rst_b)
        (state_q == seq_pkg::ST_IDLE && enabled && parallel_vid_mode_mode) |=> state_q == seq_pkg::ST_RAMP)
        else $error("delay used in parallel mode");
    a_ramp_start: assert property (@(posedge mclk_in) disable iff (!rst_b)
        $rose(state_q == seq_pkg::ST_RAMP) |-> $past(enabled))
        else $error("ramp started while not enabled");
    a_freq_range: assert property (@(posedge mclk_in) disable iff (!rst_b)
        freq_q >= seq_pkg::FREQ_MIN_KHZ && freq_q <= seq_pkg::FREQ_MAX_KHZ)
        else $error("frequency out of range");
    a_rise_nonzero: assert property (@(posedge mclk_in) disable iff (!rst_b)
        ton_rise_q != 7'h00)
        else $error("zero ramp time");
    a_parallel_vid_mode_slew: assert property (@(posedge mclk_in) disable iff (!rst_b)
        (state_q == seq_pkg::ST_RAMP && parallel_vid_mode_mode && enabled)
            |=> vref_q <= 16'($past(vref_q) + 16'(seq_pkg::VID_STEP_MV)))
        else $error("parallel slew too fast");
endmodule // reg_startup_seq

// ---- verification/pmbus_host_model.sv ----
`timescale 1ns/1ps
module pmbus_host_model (
    // clock and read data
    input  wire logic        mclk_in,
    input  wire logic [31:0] rdata_in,
    // register port and code pins
    output logic      [7:0]  addr_out,
    output logic      [31:0] wdata_out,
    output logic             wr_out,
    output logic             rd_out,
    output logic      [7:0]  vid_out
);
    initial begin
        addr_out = 8'h00;
        wdata_out = 32'h0000_0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
        vid_out = 8'h00;
    end
    // software enable and frequency reach the device only through this write
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        addr_out <= a;
        wdata_out <= v;
        wr_out <= 1'b1;
        @(posedge mclk_in);
        wr_out <= 1'b0;
        wdata_out <= ~v;
        @(posedge mclk_in);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge mclk_in);
        rd_out <= 1'b0;
        @(posedge mclk_in);
        v = rdata_in;
    endtask
endmodule // pmbus_host_model

// ---- verification/regulator_startup_sequencer_test.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("unexpected %0t %h %h", $time, (a), (b)); end end
module regulator_startup_sequencer_test;
    localparam int MS = 20;
    logic        mclk = 1'b0, rst_b = 1'b0, sup = 1'b0, pin = 1'b0, cfg = 1'b0, hsp = 1'b0;
    logic [2:0]  cnt = 3'h0;
    logic [15:0] adc = 16'h0000, vref, von, voff, vrep;
    logic [31:0] wdata, rdata, d, r;
    logic [7:0]  addr, voltage_id_code, code;
    logic        wr, rd, conv, hs, ls, armed;
    logic [3:0]  lsw;
    logic [10:0] freq;
    int          errors = 0, n_tests = 0;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) cnt <= cnt + 3'h1;
    pmbus_host_model u_host (.mclk_in(mclk), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .vid_out(voltage_id_code));
    reg_startup_seq #(.MS_CYC(MS), .SLEW_CYC(4)) u_dut (.mclk_in(mclk), .rst_b_in(rst_b),
        .bus_input_supply_ok_in(sup), .enable_pin_ok_in(pin), .config_loaded_in(cfg),
        .voltage_id_code_in(voltage_id_code), .switch_cycle_in(cnt[2]), .high_side_pulse_in(hsp),
        .vin_adc_in(adc), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .convert_en_out(conv), .high_side_switch_en_out(hs),
        .low_side_switch_en_out(ls), .low_side_width_out(lsw), .vref_mv_out(vref),
        .vin_on_out(von), .vin_off_out(voff), .freq_khz_out(freq),
        .protect_armed_out(armed), .vin_report_out(vrep));
    function automatic logic [15:0] exp_mv(input logic [7:0] c);
        return (c == 8'h00) ? 16'h0000 : 16'h01EA + 16'h000A * {8'h00, c};
    endfunction
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        u_host.rd_reg(a, d);
        `CHK(d, e)
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic tally_and_finish;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        wt(12000);
        errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(98));
        wt(16);
        rst_b <= 1'b1;
        wt(3);
        // ----------------------------------------------------------
        // reset values, unmapped place, thresholds, frequency
        // ----------------------------------------------------------
        rd_chk(seq_pkg::ADDR_CTRL, 32'h0000_0002);
        rd_chk(seq_pkg::ADDR_VIN_ON, 32'h0000_1F40);
        rd_chk(seq_pkg::ADDR_TON_RISE, 32'h0000_0001);
        rd_chk(8'h20, 32'h0000_0000);
        `CHK(freq, 11'h258)
        r = $urandom;
        u_host.wr_reg(seq_pkg::ADDR_VIN_ON, {16'h0000, r[15:0]});
        u_host.wr_reg(seq_pkg::ADDR_VIN_OFF, {16'h0000, r[31:16]});
        rd_chk(seq_pkg::ADDR_VIN_OFF, {16'h0000, r[31:16]});
        `CHK(von, r[15:0])
        `CHK(voff, r[31:16])
        u_host.wr_reg(seq_pkg::ADDR_FREQ, 32'h0000_0095);
        wt(1);
        `CHK(freq, 11'h258)
        u_host.wr_reg(seq_pkg::ADDR_FREQ, 32'h0000_05DD);
        wt(1);
        `CHK(freq, 11'h258)
        u_host.wr_reg(seq_pkg::ADDR_FREQ, 32'h0000_05DC);
        wt(1);
        `CHK(freq, 11'h5DC)
        u_host.wr_reg(seq_pkg::ADDR_FREQ, 32'h0000_00FB);
        rd_chk(seq_pkg::ADDR_FREQ, 32'h0000_00FB);
        adc <= 16'($urandom);
        wt(4);
        `CHK(vrep, adc)
        `CHK(conv, 1'b0)
        // ----------------------------------------------------------
        // enable gating, delay, ramp, pre-bias, abort
        // ----------------------------------------------------------
        code = 8'($urandom_range(255, 1));
        u_host.wr_reg(seq_pkg::ADDR_VID, {24'h0, code});
        u_host.wr_reg(seq_pkg::ADDR_TON_DLY, 32'h0000_0003);
        u_host.wr_reg(seq_pkg::ADDR_TON_RISE, 32'h0000_0002);
        pin <= 1'b1;
        cfg <= 1'b1;
        wt(30);
        `CHK(conv, 1'b0)
        sup <= 1'b1;
        cfg <= 1'b0;
        wt(30);
        `CHK(conv, 1'b0)
        cfg <= 1'b1;
        wt(10);
        `CHK(conv, 1'b1)
        wt(40);
        `CHK({vref, hs, ls}, 18'h0)
        `CHK(armed, 1'b1)
        wt(70);
        `CHK(vref, exp_mv(code))
        `CHK(hs, 1'b1)
        `CHK(ls, 1'b0)
        hsp <= 1'b1;
        wt(70);
        `CHK({ls, lsw}, 5'h11)
        wt(128);
        `CHK(lsw, 4'h2)
        wt(900);
        `CHK(lsw, 4'h8)
        pin <= 1'b0;
        wt(10);
        `CHK({conv, hs, ls}, 3'h0)
        // ----------------------------------------------------------
        // software enable, then parallel code mode
        // ----------------------------------------------------------
        u_host.wr_reg(seq_pkg::ADDR_CTRL, 32'h0000_0004);
        pin <= 1'b1;
        wt(20);
        `CHK(conv, 1'b0)
        u_host.wr_reg(seq_pkg::ADDR_CTRL, 32'h0000_0005);
        wt(10);
        `CHK(conv, 1'b1)
        u_host.wr_reg(seq_pkg::ADDR_CTRL, 32'h0000_0007);
        pin <= 1'b0;
        wt(10);
        `CHK(conv, 1'b0)
        hsp <= 1'b0;
        code = 8'($urandom_range(255, 120));
        u_host.vid_out <= code;
        u_host.wr_reg(seq_pkg::ADDR_TON_DLY, 32'h0000_007F);
        u_host.wr_reg(seq_pkg::ADDR_CTRL, 32'h0000_000A);
        pin <= 1'b1;
        wt(40);
        `CHK(vref !== 16'h0000 && vref < exp_mv(code), 1'b1)
        wt(1300);
        `CHK(vref, exp_mv(code))
        tally_and_finish();
    end
endmodule // regulator_startup_sequencer_test
